// ---- teoc_cpu_model.sv ----
// Processor memory side model.
`timescale 1ns/1ps
`default_nettype none
module teoc_cpu_model (
  // Clock and reset.
  input  wire logic        i_clk,
  input  wire logic        i_rst_n,
  // Read words from the controller.
  input  wire logic        i_stall,
  input  wire logic        i_valid,
  input  wire logic [11:0] i_data,
  output logic             o_ready,
  // Write words to the controller.
  input  wire logic        i_wready,
  output logic             o_wvalid,
  output logic [11:0]      o_wdata
);
  logic [11:0] rq[$];
  logic [11:0] wq[$];
  logic        took;
  initial begin
    o_ready = 1'b0;
    o_wvalid = 1'b0;
    o_wdata = 12'h000;
    took = 1'b0;
  end
  // Words are taken where valid meets ready.
  always @(posedge i_clk) begin
    took <= o_wvalid && i_wready;
    if (i_rst_n && i_valid && o_ready) rq.push_back(i_data);
  end
  // Drive on the falling edge; an idle lane shows inverted data.
  always @(negedge i_clk) begin
    o_ready <= !i_stall && ($urandom % 4 != 0);
    if (took && wq.size() != 0) wq.delete(0);
    o_wvalid <= wq.size() != 0;
    o_wdata <= (wq.size() != 0) ? wq[0] : ~o_wdata;
  end
endmodule
`default_nettype wire

// ---- teoc_pkg.sv ----
// Package with constants and types for the tape extended operations control block.
package teoc_pkg;
  // ==========================================================================
  // Widths.
  localparam int unsigned WORD_W  = 12;
  localparam int unsigned LINE_W  = 3;
  localparam int unsigned FIELD_W = 3;
  localparam int unsigned ADDR_W  = 12;
  localparam int unsigned BLK_W   = 11;

  // ==========================================================================
  // Control register field positions, counted from the least significant bit.
  // Processor bit 0 is the most significant bit, so processor bit n is 11-n.
  localparam int unsigned XO_FIELD_HI = 11;
  localparam int unsigned XO_FIELD_LO = 9;
  localparam int unsigned XO_MARK     = 7;
  localparam int unsigned XO_IRQ_EN   = 6;
  localparam int unsigned XO_MAINT    = 5;
  localparam int unsigned XO_EXT_ADDR = 4;
  localparam int unsigned XO_NO_PAUSE = 3;
  localparam int unsigned XO_HOLD_MOT = 2;
  localparam int unsigned XO_UNIT_HI  = 1;
  localparam int unsigned XO_UNIT_LO  = 0;

  // ==========================================================================
  // Reset values and counts.
  localparam logic [11:0] XO_RESET      = 12'h000;
  localparam logic [1:0]  LINES_PER_WD  = 2'h3;
  localparam logic [11:0] QUARTER_SIZE  = 12'h100;
  localparam logic [11:0] ADDR_ZERO     = 12'h000;

  // ==========================================================================
  // Decoded control register.
  typedef struct packed {
    logic [2:0] field;
    logic       mark;
    logic       irq_en;
    logic       maint;
    logic       ext_addr;
    logic       no_pause;
    logic       hold_motion;
    logic [1:0] preunit;
  } teoc_ctl_t;

  // Tape line as seen on the three data channels.
  typedef struct packed {
    logic       strobe;
    logic [2:0] bits;
  } teoc_line_t;

  // Controller states.
  typedef enum logic [3:0] {
    TEOC_IDLE  = 4'b0001,
    TEOC_READ  = 4'b0010,
    TEOC_WRITE = 4'b0100,
    TEOC_DONE  = 4'b1000
  } teoc_state_t;
endpackage

// ---- teoc_shift.sv ----
// Line shift buffer that assembles and disassembles 12-bit words three bits at a time.
`timescale 1ns/1ps
`default_nettype none
module teoc_shift (
  // Clock and reset.
  input  wire logic        i_clk,
  input  wire logic        i_rst_n,
  // Control.
  input  wire logic        i_load,
  input  wire logic [11:0] i_load_word,
  input  wire logic        i_shift,
  input  wire logic [2:0]  i_line_in,
  // State.
  output logic [11:0]      o_word,
  output logic [2:0]       o_line_out,
  output logic [1:0]       o_count
);
  logic [11:0] line_shift_buffer_r;
  logic [1:0]  count_r;

  // Bits 0, 4 and 8 in processor numbering face the write heads.
  assign o_word     = line_shift_buffer_r;
  assign o_line_out = {line_shift_buffer_r[11], line_shift_buffer_r[7], line_shift_buffer_r[3]};
  assign o_count    = count_r;

  // Read enters at processor bits 3, 7 and 11, then each group moves left one place. A load is a write's first line.
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      line_shift_buffer_r <= 12'h000;
      count_r             <= 2'h0;
    end else if (i_load) begin
      line_shift_buffer_r <= i_load_word;
      count_r             <= 2'h1;
    end else if (i_shift) begin
      line_shift_buffer_r <= {line_shift_buffer_r[10:8], i_line_in[2],
                              line_shift_buffer_r[6:4], i_line_in[1],
                              line_shift_buffer_r[2:0], i_line_in[0]};
      count_r             <= count_r + 2'h1;
    end
  end
endmodule
`default_nettype wire

// ---- teoc_top.sv ----
// Tape extended operations control: control register, word assembly and address setup.
//
// Contract
// R1 - After both instruction words the controller runs the transfer by itself.
// R2 - Read: three bits per line then shift; four lines make a word.
// R3 - Write: three bits per line out of the buffer, reverse of reading.
// R4 - Read words go to the holding register; write words come from it.
// R5 - Software loads the control register before the first instruction word.
// R6 - Accumulator bits 0-2 select the 4K memory field.
// R7 - Control bit 3 is unused and ignored.
// R8 - Marking permission sets only with program request and console switch held.
// R9 - Bit 5 with interrupts on and done flag requests an interrupt.
// R10 - Maintenance bit blocks tape timing and data; transfer instructions substitute.
// R11 - Extended bit copies address setup into pointer; no quarter mapping.
// R12 - No-pause bit lets the processor continue once the instruction starts.
// R13 - Hold bit keeps the unit moving after completion although deselected.
// R14 - Bits 10-11 preselect one of extra transports 2 through 7.
// R15 - Software uses only single-block transfers in extended mode.
// R16 - Extended mode takes second-word bits 1-11 as the block number.
// R17 - Software loads the address setup register before an extended instruction.
// R18 - The memory pointer wraps inside its 4096-word field.
// R19 - Standard mode starts at quarter n times 400 octal.
`timescale 1ns/1ps
`default_nettype none
module teoc_top (
  // Clock and reset.
  input  wire logic        i_clk,
  input  wire logic        i_rst_n,
  // Processor instructions.
  input  wire logic        i_load_ext_ops_from_acc,
  input  wire logic        i_load_addr_setup,
  input  wire logic [11:0] i_acc,
  input  wire logic        i_instr_word1,
  input  wire logic        i_instr_write,
  input  wire logic [2:0]  i_instr_quarter,
  input  wire logic        i_instr_word2,
  input  wire logic [11:0] i_instr_data,
  input  wire logic        i_int_enabled,
  // Console and formatting program.
  input  wire logic        i_mark_switch,
  input  wire logic        i_mark_request,
  // Tape side.
  input  wire logic        i_tape_strobe,
  input  wire logic [2:0]  i_tape_line,
  input  wire logic        i_block_end,
  // Maintenance transfer instructions.
  input  wire logic        i_io_transfer_instruction,
  input  wire logic [2:0]  i_maint_line,
  // Memory side.
  output logic             o_mem_valid,
  output logic [11:0]      o_mem_data,
  output logic [11:0]      o_mem_addr,
  output logic [2:0]       o_mem_field,
  input  wire logic        i_mem_ready,
  input  wire logic        i_mem_wvalid,
  input  wire logic [11:0] i_mem_wdata,
  output logic             o_mem_wready,
  // Status and controls.
  output logic [2:0]       o_tape_line,
  output logic             o_write_enable,
  output logic [10:0]      o_target_block_number,
  output logic             o_cp_pause,
  output logic             o_tape_done,
  output logic             o_int_request,
  output logic             o_mark_enable,
  output logic             o_maint_mode,
  output logic             o_unit_motion,
  output logic [1:0]       o_preunit
);
  teoc_pkg::teoc_ctl_t  extended_ops_control_r;
  teoc_pkg::teoc_state_t state_r;
  teoc_pkg::teoc_line_t  line_src;
  logic [11:0]           addr_setup_r;
  logic [11:0]           tape_memory_pointer_r;
  logic [11:0]           tape_word_holding_r;
  logic                  hold_full_r;
  logic [10:0]           target_block_number_r;
  logic                  write_r;
  logic                  done_r;
  logic                  pause_r;
  logic                  motion_r;
  logic                  irq_r;
  logic [11:0]           sh_word;
  logic [2:0]            sh_line_out;
  logic [1:0]            sh_count;
  logic                  sh_load;
  logic                  sh_shift;
  logic                  word_ready;
  logic                  buf_in_ready;
  logic                  buf_out_valid;
  logic [11:0]           buf_out_data;
  logic                  wr_need;

  // Wrapping increment inside a 4096-word field; the carry is dropped on purpose.
  function automatic logic [11:0] teoc_inc(input logic [11:0] a);
    teoc_inc = a + 12'h001; // R18
  endfunction

  // Start address of a memory quarter.
  function automatic logic [11:0] teoc_quarter(input logic [2:0] q);
    teoc_quarter = 12'({q, 8'h00}); // R19
  endfunction

  // ==========================================================================
  // Line source: maintenance mode shuts the tape out and uses the substitute path.
  always_comb begin
    if (extended_ops_control_r.maint) begin
      line_src.strobe = i_io_transfer_instruction; // R10
      line_src.bits   = i_maint_line;
    end else begin
      line_src.strobe = i_tape_strobe;
      line_src.bits   = i_tape_line;
    end
  end

  // Read shifts wait while a word is held; write shifts run out the loaded word.
  assign sh_shift   = line_src.strobe && (((state_r == teoc_pkg::TEOC_READ) && !word_ready) ||
                      ((state_r == teoc_pkg::TEOC_WRITE) && sh_count != 2'h0)); // R2 R3
  assign wr_need    = (state_r == teoc_pkg::TEOC_WRITE) && line_src.strobe && hold_full_r
                      && (sh_count == 2'h0);
  assign sh_load    = wr_need; // R4
  assign word_ready = (state_r == teoc_pkg::TEOC_READ) && hold_full_r;
  assign o_mem_wready = (state_r == teoc_pkg::TEOC_WRITE) && !hold_full_r;

  // ==========================================================================
  // Shift buffer.
  teoc_shift u_shift (
    .i_clk       (i_clk),
    .i_rst_n     (i_rst_n),
    .i_load      (sh_load),
    .i_load_word (tape_word_holding_r),
    .i_shift     (sh_shift),
    .i_line_in   (line_src.bits),
    .o_word      (sh_word),
    .o_line_out  (sh_line_out),
    .o_count     (sh_count)
  );

  // Read words queue toward memory; a stalled memory loses nothing until both entries and the holding register are full.
  teoc_wordbuf u_buf (
    .i_clk       (i_clk),
    .i_rst_n     (i_rst_n),
    .i_in_valid  (word_ready),
    .i_in_data   (tape_word_holding_r),
    .o_in_ready  (buf_in_ready),
    .o_out_valid (buf_out_valid),
    .o_out_data  (buf_out_data),
    .i_out_ready (i_mem_ready && !o_mem_valid)
  );

  // ==========================================================================
  // Control register load; bit 3 is simply not stored.
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      extended_ops_control_r <= '0;
    end else if (i_load_ext_ops_from_acc) begin
      extended_ops_control_r.field       <= i_acc[teoc_pkg::XO_FIELD_HI:teoc_pkg::XO_FIELD_LO]; // R6 R7
      extended_ops_control_r.mark        <= i_acc[teoc_pkg::XO_MARK] && i_mark_request
                                            && i_mark_switch; // R8
      extended_ops_control_r.irq_en      <= i_acc[teoc_pkg::XO_IRQ_EN];
      extended_ops_control_r.maint       <= i_acc[teoc_pkg::XO_MAINT];
      extended_ops_control_r.ext_addr    <= i_acc[teoc_pkg::XO_EXT_ADDR];
      extended_ops_control_r.no_pause    <= i_acc[teoc_pkg::XO_NO_PAUSE];
      extended_ops_control_r.hold_motion <= i_acc[teoc_pkg::XO_HOLD_MOT];
      extended_ops_control_r.preunit     <= i_acc[teoc_pkg::XO_UNIT_HI:teoc_pkg::XO_UNIT_LO]; // R14
    end
  end

  // Address setup register.
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      addr_setup_r <= teoc_pkg::ADDR_ZERO;
    end else if (i_load_addr_setup) begin
      addr_setup_r <= i_acc;
    end
  end

  // ==========================================================================
  // Sequencer: first word arms, second word starts, block end finishes.
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      state_r <= teoc_pkg::TEOC_IDLE;
      write_r <= 1'b0;
    end else begin
      unique case (state_r)
        teoc_pkg::TEOC_IDLE: begin
          if (i_instr_word1) begin
            write_r <= i_instr_write;
          end
          if (i_instr_word2) begin
            state_r <= write_r ? teoc_pkg::TEOC_WRITE : teoc_pkg::TEOC_READ; // R1
          end
        end
        teoc_pkg::TEOC_READ,
        teoc_pkg::TEOC_WRITE: begin
          if (i_block_end) begin
            state_r <= teoc_pkg::TEOC_DONE;
          end
        end
        teoc_pkg::TEOC_DONE: begin
          state_r <= teoc_pkg::TEOC_IDLE;
        end
      endcase
    end
  end

  // Pointer is set up at the first word, block number at the second word.
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      tape_memory_pointer_r <= teoc_pkg::ADDR_ZERO;
      target_block_number_r <= 11'h000;
    end else if (state_r == teoc_pkg::TEOC_IDLE && i_instr_word1) begin
      tape_memory_pointer_r <= extended_ops_control_r.ext_addr ? addr_setup_r
                               : teoc_quarter(i_instr_quarter); // R11 R19
    end else if (state_r == teoc_pkg::TEOC_IDLE && i_instr_word2) begin
      target_block_number_r <= extended_ops_control_r.ext_addr ? i_instr_data[10:0]
                               : {2'h0, i_instr_data[8:0]}; // R16
    end else if ((o_mem_valid && i_mem_ready) || (i_mem_wvalid && o_mem_wready)) begin
      tape_memory_pointer_r <= teoc_inc(tape_memory_pointer_r); // R18
    end
  end

  // Holding register: read fills it from the shift buffer, write fills it from memory.
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      tape_word_holding_r <= 12'h000;
      hold_full_r         <= 1'b0;
    end else if (state_r == teoc_pkg::TEOC_READ) begin
      if (word_ready && buf_in_ready) begin
        hold_full_r <= 1'b0;
      end else if (!hold_full_r && sh_shift && sh_count == teoc_pkg::LINES_PER_WD) begin
        tape_word_holding_r <= {sh_word[10:8], line_src.bits[2], sh_word[6:4], line_src.bits[1],
                                sh_word[2:0], line_src.bits[0]}; // R4
        hold_full_r         <= 1'b1;
      end
    end else if (state_r == teoc_pkg::TEOC_WRITE) begin
      if (i_mem_wvalid && o_mem_wready) begin
        tape_word_holding_r <= i_mem_wdata; // R4
        hold_full_r         <= 1'b1;
      end else if (sh_load) begin
        hold_full_r <= 1'b0;
      end
    end else begin
      hold_full_r <= 1'b0;
    end
  end

  // Memory write port holds a word until memory takes it.
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_mem_valid <= 1'b0;
      o_mem_data  <= 12'h000;
    end else if (o_mem_valid) begin
      if (i_mem_ready) begin
        o_mem_valid <= 1'b0;
      end
    end else if (buf_out_valid && i_mem_ready) begin
      o_mem_valid <= 1'b1;
      o_mem_data  <= buf_out_data;
    end
  end

  // ==========================================================================
  // Registered outputs toward tape and memory.
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_mem_addr            <= teoc_pkg::ADDR_ZERO;
      o_mem_field           <= 3'h0;
      o_tape_line           <= 3'h0;
      o_write_enable        <= 1'b0;
      o_target_block_number <= 11'h000;
      o_mark_enable         <= 1'b0;
      o_maint_mode          <= 1'b0;
      o_preunit             <= 2'h0;
    end else begin
      o_mem_addr            <= tape_memory_pointer_r;
      o_mem_field           <= extended_ops_control_r.field; // R6
      o_tape_line           <= sh_line_out; // R3
      o_write_enable        <= (state_r == teoc_pkg::TEOC_WRITE) && !extended_ops_control_r.maint;
      o_target_block_number <= target_block_number_r;
      o_mark_enable         <= extended_ops_control_r.mark;
      o_maint_mode          <= extended_ops_control_r.maint;
      o_preunit             <= extended_ops_control_r.preunit;
    end
  end

  // Done flag, processor pause and unit motion.
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      done_r   <= 1'b0;
      pause_r  <= 1'b0;
      motion_r <= 1'b0;
    end else begin
      if (state_r == teoc_pkg::TEOC_DONE) begin
        done_r <= 1'b1;
      end else if (i_instr_word1) begin
        done_r <= 1'b0;
      end
      if (state_r == teoc_pkg::TEOC_IDLE && i_instr_word2) begin
        pause_r  <= !extended_ops_control_r.no_pause; // R12
        motion_r <= 1'b1;
      end else if (state_r == teoc_pkg::TEOC_DONE) begin
        pause_r  <= 1'b0;
        motion_r <= extended_ops_control_r.hold_motion; // R13
      end
    end
  end

  // Interrupt request level.
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      irq_r <= 1'b0;
    end else begin
      irq_r <= extended_ops_control_r.irq_en && i_int_enabled && done_r; // R9
    end
  end

  assign o_cp_pause    = pause_r;
  assign o_tape_done   = done_r;
  assign o_int_request = irq_r;
  assign o_unit_motion = motion_r;
endmodule
`default_nettype wire

// ---- teoc_top_props.sv ----
// Concurrent checks on the top module's ports.
`timescale 1ns/1ps
`default_nettype none
module teoc_top_props (
  // Clock, reset and inputs.
  input wire logic        i_clk,
  input wire logic        i_rst_n,
  input wire logic        i_load_ext_ops_from_acc,
  input wire logic [11:0] i_acc,
  input wire logic        i_mark_switch,
  input wire logic        i_mark_request,
  input wire logic        i_instr_word1,
  input wire logic        i_instr_word2,
  input wire logic [11:0] i_instr_data,
  input wire logic        i_int_enabled,
  input wire logic        i_mem_ready,
  // Outputs watched.
  input wire logic        o_mem_valid,
  input wire logic [11:0] o_mem_data,
  input wire logic [2:0]  o_mem_field,
  input wire logic [10:0] o_target_block_number,
  input wire logic        o_cp_pause,
  input wire logic        o_tape_done,
  input wire logic        o_int_request,
  input wire logic        o_mark_enable,
  input wire logic        o_maint_mode,
  input wire logic [1:0]  o_preunit,
  input wire logic        o_write_enable
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);
  logic [11:0] acc_l;
  logic [11:0] blk_l;
  logic        mk_l;
  // ==========================================================================
  // Loads are captured; outputs are judged two edges later.
  always_ff @(posedge i_clk) begin
    if (i_load_ext_ops_from_acc) acc_l <= i_acc;
    if (i_load_ext_ops_from_acc) mk_l <= i_acc[7] & i_mark_request & i_mark_switch;
    if (i_instr_word2) blk_l <= i_instr_data;
  end
  // ==========================================================================
  // Assertions.
  chk_field_load: assert property (i_load_ext_ops_from_acc |-> ##2 o_mem_field == acc_l[11:9])
    else $error("field not loaded");
  chk_unit_load: assert property (i_load_ext_ops_from_acc |-> ##2 o_preunit == acc_l[1:0])
    else $error("preunit not loaded");
  chk_maint_load: assert property (i_load_ext_ops_from_acc |-> ##2 o_maint_mode == acc_l[5])
    else $error("maint not loaded");
  chk_mark_gate: assert property (i_load_ext_ops_from_acc |-> ##2 o_mark_enable == mk_l)
    else $error("mark gate broken");
  chk_irq_gate: assert property ((!i_int_enabled) [*2] |-> !o_int_request)
    else $error("irq while disabled");
  chk_pause_release: assert property (o_tape_done [*2] |-> !o_cp_pause)
    else $error("pause after done");
  chk_read_hold: assert property (o_mem_valid && !i_mem_ready |=> o_mem_valid && $stable(o_mem_data))
    else $error("stalled word lost");
  chk_block_take: assert property (i_instr_word2 |-> ##2 o_target_block_number[8:0] == blk_l[8:0])
    else $error("block not taken");
  chk_done_clear: assert property (i_instr_word1 |-> ##2 !o_tape_done)
    else $error("done not cleared");
  // Main scenarios reached.
  cov_stall: cover property (o_mem_valid && !i_mem_ready);
  cov_mark: cover property ($rose(o_mark_enable));
  cov_irq: cover property (o_int_request);
  cov_write: cover property (o_write_enable);
endmodule
bind teoc_top teoc_top_props u_props (.i_clk(i_clk), .i_rst_n(i_rst_n),
  .i_load_ext_ops_from_acc(i_load_ext_ops_from_acc), .i_acc(i_acc), .i_mark_switch(i_mark_switch),
  .i_mark_request(i_mark_request), .i_instr_word1(i_instr_word1), .i_instr_word2(i_instr_word2),
  .i_instr_data(i_instr_data), .i_int_enabled(i_int_enabled), .i_mem_ready(i_mem_ready),
  .o_mem_valid(o_mem_valid), .o_mem_data(o_mem_data), .o_mem_field(o_mem_field),
  .o_target_block_number(o_target_block_number), .o_cp_pause(o_cp_pause), .o_tape_done(o_tape_done),
  .o_int_request(o_int_request), .o_mark_enable(o_mark_enable), .o_maint_mode(o_maint_mode),
  .o_preunit(o_preunit), .o_write_enable(o_write_enable));
`default_nettype wire

// ---- teoc_wordbuf.sv ----
// Two-entry word buffer with valid and ready on both sides.
`timescale 1ns/1ps
`default_nettype none
module teoc_wordbuf (
  // Clock and reset.
  input  wire logic        i_clk,
  input  wire logic        i_rst_n,
  // Filling side.
  input  wire logic        i_in_valid,
  input  wire logic [11:0] i_in_data,
  output logic             o_in_ready,
  // Draining side.
  output logic             o_out_valid,
  output logic [11:0]      o_out_data,
  input  wire logic        i_out_ready
);
  logic [11:0] mem_r [2];
  logic        wp_r;
  logic        rp_r;
  logic [1:0]  cnt_r;
  logic        push;
  logic        pop;

  // Ready and valid come straight from the occupancy count.
  assign o_in_ready  = (cnt_r != 2'h2);
  assign o_out_valid = (cnt_r != 2'h0);
  assign o_out_data  = mem_r[rp_r];
  assign push        = i_in_valid && o_in_ready;
  assign pop         = o_out_valid && i_out_ready;

  // Storage is written only on a push, so no reset is needed there.
  always_ff @(posedge i_clk) begin
    if (push) begin
      mem_r[wp_r] <= i_in_data;
    end
  end

  // Pointers and count.
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      wp_r  <= 1'b0;
      rp_r  <= 1'b0;
      cnt_r <= 2'h0;
    end else begin
      if (push) begin
        wp_r <= ~wp_r;
      end
      if (pop) begin
        rp_r <= ~rp_r;
      end
      cnt_r <= cnt_r + {1'b0, push} - {1'b0, pop};
    end
  end
endmodule
`default_nettype wire

// ---- test_tape_extended_ops_control.sv ----
// Self-checking bench.
`timescale 1ns/1ps
`default_nettype none
module test_tape_extended_ops_control;
  logic        i_clk, i_rst_n, ld_xo, ld_set, w1, wr, w2, int_en, msw, mrq, strb, bend, io_transfer_instruction, stall, mm;
  logic        mv, mready, wv, wrdy, we, pause, done, irq, mark, maint, motion;
  logic [2:0]  qtr, tline, mline, field, oline;
  logic [11:0] acc, idata, mdata, maddr, wdata, d, e;
  logic [10:0] blk;
  logic [1:0]  pre;
  logic [11:0] em[$];
  int          n_mismatch, n_tests;
  teoc_top dut (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_load_ext_ops_from_acc(ld_xo), .i_load_addr_setup(ld_set),
    .i_acc(acc), .i_instr_word1(w1), .i_instr_write(wr), .i_instr_quarter(qtr), .i_instr_word2(w2),
    .i_instr_data(idata), .i_int_enabled(int_en), .i_mark_switch(msw), .i_mark_request(mrq),
    .i_tape_strobe(strb), .i_tape_line(tline), .i_block_end(bend), .i_io_transfer_instruction(io_transfer_instruction),
    .i_maint_line(mline), .o_mem_valid(mv), .o_mem_data(mdata), .o_mem_addr(maddr), .o_mem_field(field),
    .i_mem_ready(mready), .i_mem_wvalid(wv), .i_mem_wdata(wdata), .o_mem_wready(wrdy), .o_tape_line(oline),
    .o_write_enable(we), .o_target_block_number(blk), .o_cp_pause(pause), .o_tape_done(done),
    .o_int_request(irq), .o_mark_enable(mark), .o_maint_mode(maint), .o_unit_motion(motion), .o_preunit(pre));
  teoc_cpu_model cpu (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_stall(stall), .i_valid(mv), .i_data(mdata),
    .o_ready(mready), .i_wready(wrdy), .o_wvalid(wv), .o_wdata(wdata));
  // ==========================================================================
  // Clock at 20 MHz.
  initial begin
    i_clk = 1'b0;
    forever #25 i_clk = ~i_clk;
  end
  // ==========================================================================
  // Shared tasks.
  task automatic chk(string nm, logic [11:0] exp, logic [11:0] got);
    n_tests++;
    if (got !== exp) begin
      n_mismatch++;
      $display("wrong value %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic cyc(int n);
    repeat (n) @(negedge i_clk);
  endtask
  // An idle cycle follows each pulse, so no double assignment.
  task automatic pulse(ref logic s);
    s = 1'b1;
    cyc(1);
    s = 1'b0;
    cyc(1);
  endtask
  task automatic xo(logic [11:0] v);
    acc = v;
    pulse(ld_xo);
    cyc(1);
    chk("xo", 12'({v[11:9], v[7] & mrq & msw, v[5], v[1:0]}), 12'({field, mark, maint, pre}));
  endtask
  task automatic instr(logic w, logic [2:0] q, logic [11:0] dd);
    wr = w;
    qtr = q;
    idata = dd;
    pulse(w1);
    pulse(w2);
    cyc(2);
  endtask
  // Top bit of each group first; maintenance adds a transfer-instruction strobe and puts inverted junk on the tape line.
  task automatic rd(int n);
    logic [11:0] w;
    for (int i = 0; i < n; i++) begin
      w = 12'($urandom);
      em.push_back(w);
      for (int k = 0; k < 4; k++) begin
        cyc($urandom_range(1, 3));
        mline = {w[11-k], w[7-k], w[3-k]};
        tline = mm ? ~mline : mline;
        if (mm) pulse(io_transfer_instruction);
        pulse(strb);
        tline = 3'($urandom);
      end
    end
  endtask
  task automatic drain();
    for (int t = 0; t < 400 && cpu.rq.size() < em.size(); t++) cyc(1);
    chk("count", 12'(em.size()), 12'(cpu.rq.size()));
    while (em.size() != 0 && cpu.rq.size() != 0) chk("word", em.pop_front(), cpu.rq.pop_front());
    em.delete();
  endtask
  task automatic tally_and_finish();
    if (n_mismatch == 0 && n_tests > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  // Watchdog: over a hundred times the expected run.
  initial begin
    #2000000;
    n_mismatch++;
    tally_and_finish();
  end
  // ==========================================================================
  // Main sequence.
  initial begin
    {i_rst_n, ld_xo, ld_set, w1, wr, w2, int_en, msw, mrq, strb, bend, io_transfer_instruction, stall, mm} = '0;
    {qtr, tline, mline, acc, idata} = '0;
    n_mismatch = 0;
    n_tests = 0;
    void'($urandom(73273));
    cyc(3);
    i_rst_n = 1'b1;
    // Every console combination, unused bit 3 random.
    for (int i = 0; i < 8; i++) begin
      {mrq, msw} = 2'(i);
      xo((12'($urandom) & 12'hf7f) | {4'h0, i[2], 7'h00});
    end
    // Standard read, quarter 3, receiver stalled.
    {mrq, msw, int_en} = 3'b001;
    xo(12'ha44);
    instr(1'b0, 3'h3, 12'h5a5);
    chk("block", 12'h1a5, {1'b0, blk});
    chk("addr", 12'h300, maddr);
    chk("pause", 12'h001, {11'h0, pause});
    stall = 1'b1;
    rd(3);
    stall = 1'b0;
    drain();
    pulse(bend);
    cyc(2);
    chk("status", 12'h00e, {8'h0, done, irq, motion, pause});
    chk("addr", 12'h303, maddr);
    // Extended read wrapping in the field.
    int_en = 1'b0;
    xo(12'h418);
    acc = 12'hffe;
    pulse(ld_set);
    d = 12'($urandom);
    instr(1'b0, 3'h6, d);
    chk("block", {1'b0, d[10:0]}, {1'b0, blk});
    chk("addr", 12'hffe, maddr);
    chk("pause", 12'h000, {11'h0, pause});
    rd(3);
    drain();
    pulse(bend);
    cyc(2);
    chk("addr", 12'h001, maddr);
    chk("status", 12'h008, {8'h0, done, irq, motion, pause});
    // Write two words via the holding register.
    xo(12'h000);
    instr(1'b1, 3'h1, 12'h012);
    chk("wen", 12'h001, {11'h0, we});
    d = 12'($urandom);
    cpu.wq.push_back(d);
    cpu.wq.push_back(~d);
    for (int i = 0; i < 8; i++) begin
      cyc(3);
      e = (i < 4) ? d : ~d;
      pulse(strb);
      chk("line", 12'({e[11-i%4], e[7-i%4], e[3-i%4]}), 12'(oline));
    end
    pulse(bend);
    // Maintenance read: lines come only from transfer instructions.
    mm = 1'b1;
    xo(12'h020);
    instr(1'b0, 3'h0, 12'h000);
    rd(2);
    drain();
    tally_and_finish();
  end
endmodule
`default_nettype wire
